//--- core/mcu_address_space_decoder.sv
`timescale 1ns/1ns
module mcu_address_space_decoder
#(
	parameter int RAM_BYTES  = addr_space_pkg::DATA_RAM_BYTES,
	parameter int PROG_WORDS = addr_space_pkg::USER_PROG_WORDS
)
(
	input  wire logic                                     i_ref_clk,
	input  wire logic                                     i_rst_n,
	// Fetch unit
	input  wire logic                                     i_pc_step,
	input  wire logic                                     i_pc_back,
	input  wire logic                                     i_pc_load,
	input  wire logic [addr_space_pkg::PC_W-1:0]          i_pc_target,
	// Table operations
	input  wire logic                                     i_table_read_op,
	input  wire logic                                     i_table_write_op,
	input  wire logic [addr_space_pkg::PAGE_W-1:0]        i_table_page_select,
	input  wire logic [15:0]                              i_table_offset,
	// Read address generation unit
	input  wire logic                                     i_rd_valid,
	input  wire logic [addr_space_pkg::DATA_ADDR_W-1:0]   i_rd_byte_effective_address,
	input  wire logic                                     i_rd_byte_op,
	input  wire logic                                     i_program_window_enable,
	input  wire logic [addr_space_pkg::PAGE_W-1:0]        i_visibility_page,
	// Write address generation unit
	input  wire logic                                     i_wr_valid,
	input  wire logic [addr_space_pkg::DATA_ADDR_W-1:0]   i_wr_byte_effective_address,
	// Memory read data
	input  wire logic [addr_space_pkg::DATA_W-1:0]        i_ram_rdata,
	input  wire logic [addr_space_pkg::PROG_WORD_W-1:0]   i_prog_rdata,
	// Outputs
	output logic      [addr_space_pkg::PC_W-1:0]          o_pc,
	output logic      [addr_space_pkg::PROG_ADDR_W-1:0]   o_prog_addr,
	output logic                                          o_prog_en,
	output logic                                          o_prog_config,
	output logic      [3:0]                               o_prog_region,
	output logic      [13:0]                              o_ram_rd_addr,
	output logic                                          o_ram_rd_en,
	output logic      [13:0]                              o_ram_wr_addr,
	output logic                                          o_ram_wr_en,
	output logic      [addr_space_pkg::DATA_W-1:0]        o_rd_data,
	output logic                                          o_rd_data_valid
);
	import addr_space_pkg::*;

	if (RAM_BYTES < 2 || RAM_BYTES > DATA_RAM_BYTES)
	begin : g_ram_size_check
		$error("RAM_BYTES out of range");
	end
	if (PROG_WORDS < 256 || PROG_WORDS > 24'h400000)
	begin : g_prog_size_check
		$error("PROG_WORDS out of range");
	end

	localparam logic [15:0] RAM_LIMIT  = 16'(RAM_BYTES);
	localparam logic [23:0] PROG_LIMIT = 24'(PROG_WORDS * PC_STEP);

	// Program counter, lower-word aligned
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_pc <= PC_RESET;
		else if (i_pc_load)
			o_pc <= {i_pc_target[PC_W-1:1], 1'b0};
		else if (i_pc_step && i_pc_back)
			o_pc <= o_pc - 23'(PC_STEP);
		else if (i_pc_step)
			o_pc <= o_pc + 23'(PC_STEP);
	end

	// Program address source; table ops take priority over window, then fetch
	logic        table_op;
	logic        data_win;
	logic [23:0] next_prog_addr;
	logic        next_config;
	assign table_op = i_table_read_op | i_table_write_op;
	assign data_win = i_rd_valid && i_rd_byte_effective_address[WINDOW_SEL_BIT]
		&& i_program_window_enable;

	always_comb
	begin
		next_config = 1'b0;
		if (table_op)
		begin
			next_prog_addr = {i_table_page_select, i_table_offset[15:1], 1'b0};
			next_config    = i_table_page_select[TABLE_PAGE_CFG_BIT];
		end
		else if (data_win)
			// 16K-word page: page picks bits 22:15, address bits 14:1 the word
			next_prog_addr = {1'b0, i_visibility_page,
				i_rd_byte_effective_address[14:1], 1'b0};
		else
			next_prog_addr = {1'b0, o_pc};
	end

	prog_region_t next_region;
	always_comb
	begin
		if (next_config)
			next_region = REGION_CONFIG;
		else if (next_prog_addr <= RESET_START_ADDR)
			next_region = REGION_RESET;
		else if (next_prog_addr >= PRIMARY_IVT_LO && next_prog_addr <= ALT_IVT_HI)
			next_region = REGION_IVT;
		else
			next_region = REGION_USER;
	end

	logic prog_impl;
	assign prog_impl = next_config || next_prog_addr < PROG_LIMIT;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_prog_addr   <= RESET_JUMP_ADDR;
			o_prog_en     <= 1'b0;
			o_prog_config <= 1'b0;
			o_prog_region <= 4'h0;
		end
		else
		begin
			o_prog_addr   <= next_prog_addr;
			o_prog_en     <= prog_impl && (next_config || next_prog_addr <= USER_TOP);
			o_prog_config <= next_config;
			o_prog_region <= next_region;
		end
	end

	// Data RAM decode
	logic rd_ram_hit;
	logic wr_ram_hit;
	assign rd_ram_hit = i_rd_valid && !i_rd_byte_effective_address[WINDOW_SEL_BIT]
		&& i_rd_byte_effective_address < RAM_LIMIT;
	assign wr_ram_hit = i_wr_valid && !i_wr_byte_effective_address[WINDOW_SEL_BIT]
		&& i_wr_byte_effective_address < RAM_LIMIT;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_ram_rd_addr <= 14'h0000;
			o_ram_rd_en   <= 1'b0;
			o_ram_wr_addr <= 14'h0000;
			o_ram_wr_en   <= 1'b0;
		end
		else
		begin
			o_ram_rd_addr <= {1'b0, i_rd_byte_effective_address[13:1]};
			o_ram_rd_en   <= rd_ram_hit;
			o_ram_wr_addr <= {1'b0, i_wr_byte_effective_address[13:1]};
			o_ram_wr_en   <= wr_ram_hit;
		end
	end

	// Read return: memory answers in the same cycle the address is registered
	logic       rd_pend;
	logic [1:0] rd_src;
	logic       rd_odd;
	logic       rd_byte;
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rd_pend <= 1'b0;
			rd_src  <= 2'b00;
			rd_odd  <= 1'b0;
			rd_byte <= 1'b0;
		end
		else
		begin
			rd_pend <= i_rd_valid;
			rd_src  <= {data_win && prog_impl, rd_ram_hit};
			rd_odd  <= i_rd_byte_effective_address[0];
			rd_byte <= i_rd_byte_op;
		end
	end

	// Window reads return the lower word only
	logic [15:0] src_word;
	logic [15:0] lane_word;
	always_comb
	begin
		case (rd_src)
			2'b01:   src_word = i_ram_rdata;
			2'b10:   src_word = i_prog_rdata[15:0];
			default: src_word = 16'h0000;
		endcase
	end

	data_byte_lane u_lane
	(
		.i_word    (src_word),
		.i_odd     (rd_odd),
		.i_byte_op (rd_byte),
		.o_data    (lane_word)
	);

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rd_data       <= 16'h0000;
			o_rd_data_valid <= 1'b0;
		end
		else
		begin
			o_rd_data       <= lane_word;
			o_rd_data_valid <= rd_pend;
		end
	end

	sequence s_unmapped_read;
		i_rd_valid && !i_rd_byte_effective_address[WINDOW_SEL_BIT]
			&& i_rd_byte_effective_address >= RAM_LIMIT;
	endsequence

	sequence s_window_off_read;
		i_rd_valid && i_rd_byte_effective_address[WINDOW_SEL_BIT]
			&& !i_program_window_enable && !table_op;
	endsequence

	// No memory strobe, then a zero word that is still flagged valid
	sequence s_zero_return;
		!o_ram_rd_en ##1 (o_rd_data == 16'h0000 && o_rd_data_valid);
	endsequence

	AST_RESET_PC: assert property (
		@(posedge i_ref_clk) $rose(i_rst_n) |-> o_pc == PC_RESET)
		else $error("PC not at reset address");
	AST_PC_STEP: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_pc_step && !i_pc_back && !i_pc_load |=> o_pc == $past(o_pc) + 23'(PC_STEP))
		else $error("PC forward step wrong");
	AST_PC_BACK: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_pc_step && i_pc_back && !i_pc_load |=> o_pc == $past(o_pc) - 23'(PC_STEP))
		else $error("PC backward step wrong");
	AST_PC_ALIGN: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_pc_load |=> o_pc[0] == 1'b0)
		else $error("PC not aligned");
	AST_UNMAPPED_ZERO: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_unmapped_read |=> s_zero_return)
		else $error("Unimplemented data not zero");
	AST_WINDOW_OFF: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_window_off_read |=> s_zero_return)
		else $error("Window visible while disabled");
	AST_WINDOW_MAP: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		data_win && !table_op |=> o_prog_addr[22:15] == $past(i_visibility_page)
		&& o_prog_addr[14:1] == $past(i_rd_byte_effective_address[14:1]))
		else $error("Window page mapping wrong");
	AST_TABLE_CFG: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		table_op |=> o_prog_config == $past(i_table_page_select[TABLE_PAGE_CFG_BIT]))
		else $error("Config access not from page bit");
	AST_USER_LIMIT: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_prog_en && !o_prog_config |-> o_prog_addr <= USER_TOP)
		else $error("User access above user range");
	AST_RAM_HIT: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		rd_ram_hit |=> o_ram_rd_en
		&& o_ram_rd_addr[12:0] == $past(i_rd_byte_effective_address[13:1]))
		else $error("RAM read decode wrong");
endmodule : mcu_address_space_decoder

//--- core/addr_space_pkg.sv
package addr_space_pkg;
	localparam int          PROG_ADDR_W        = 24;
	localparam int          PC_W               = 23;
	localparam int          DATA_ADDR_W        = 16;
	localparam int          DATA_W             = 16;
	localparam int          PAGE_W             = 8;
	localparam int          PROG_WORD_W        = 24;
	localparam int          PROG_UPPER_IMPL_W  = 8;
	localparam int          WINDOW_SEL_BIT     = 15;
	localparam int          TABLE_PAGE_CFG_BIT = 7;
	localparam int          PC_STEP            = 2;
	localparam int          DATA_RAM_BYTES     = 16384;
	localparam int          USER_PROG_WORDS    = 88 * 1024;
	localparam logic [23:0] USER_TOP           = 24'h7fffff;
	localparam logic [23:0] RESET_JUMP_ADDR    = 24'h000000;
	localparam logic [23:0] RESET_START_ADDR   = 24'h000002;
	localparam logic [23:0] PRIMARY_IVT_LO     = 24'h000004;
	localparam logic [23:0] PRIMARY_IVT_HI     = 24'h0000ff;
	localparam logic [23:0] ALT_IVT_LO         = 24'h000100;
	localparam logic [23:0] ALT_IVT_HI         = 24'h0001ff;
	localparam logic [22:0] PC_RESET           = 23'h000000;

	typedef enum logic [3:0] {
		REGION_USER     = 4'h1,
		REGION_CONFIG   = 4'h2,
		REGION_IVT      = 4'h4,
		REGION_RESET    = 4'h8
	} prog_region_t;
endpackage : addr_space_pkg

//--- core/data_byte_lane.sv
`timescale 1ns/1ns
// Passes a data word whole, or for byte ops picks one byte lane; even byte address is the low byte.
module data_byte_lane
(
	input  wire logic [15:0] i_word,
	input  wire logic        i_odd,
	input  wire logic        i_byte_op,
	output logic      [15:0] o_data
);
	always_comb
	begin
		if (!i_byte_op)
			o_data = i_word;
		else if (i_odd)
			o_data = {8'h00, i_word[15:8]};
		else
			o_data = {8'h00, i_word[7:0]};
	end
endmodule : data_byte_lane

//--- test/mem_partner.sv
`timescale 1ns/1ns
module mem_partner
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_ram_rd_en,
	input  wire logic [13:0] i_ram_rd_addr,
	input  wire logic        i_prog_en,
	input  wire logic [23:0] i_prog_addr,
	output logic      [15:0] o_ram_rdata,
	output logic      [23:0] o_prog_rdata
);
	logic [23:0] noise = 24'h5a5a5a;
	// Idle buses toggle so a stale word never passes for data
	always_ff @(posedge i_ref_clk)
		noise <= ~noise;
	// Each word carries its own address so the bench can predict it
	assign o_ram_rdata = i_ram_rd_en ? {~i_ram_rd_addr[7:0], i_ram_rd_addr[7:0]} : noise[15:0];
	assign o_prog_rdata = i_prog_en ? {8'h5a, i_prog_addr[16:1]} : noise;
endmodule : mem_partner

//--- test/mcu_address_space_decoder_test.sv
`timescale 1ns/1ns
module mcu_address_space_decoder_test;
	import addr_space_pkg::*;
	typedef struct packed {
		logic [15:0] addr;
		logic        bop;
		logic        win;
		logic [7:0]  page;
		logic        ram_en;
		logic [15:0] data;
	} rd_row_t;
	logic        i_ref_clk = 0, i_rst_n = 0;
	logic        i_pc_step = 0, i_pc_back = 0, i_pc_load = 0;
	logic [22:0] i_pc_target = 0;
	logic        i_table_read_op = 0, i_table_write_op = 0;
	logic [7:0]  i_table_page_select = 0, i_visibility_page = 0;
	logic [15:0] i_table_offset = 0, i_rd_byte_effective_address = 0;
	logic        i_rd_valid = 0, i_rd_byte_op = 0, i_program_window_enable = 0, i_wr_valid = 0;
	logic [15:0] i_wr_byte_effective_address = 0, i_ram_rdata, o_rd_data;
	logic [23:0] i_prog_rdata, o_prog_addr;
	logic [22:0] o_pc;
	logic        o_prog_en, o_prog_config, o_ram_rd_en, o_ram_wr_en, o_rd_data_valid;
	logic [3:0]  o_prog_region;
	logic [13:0] o_ram_rd_addr, o_ram_wr_addr;
	int          miscompares = 0, n_compared = 0;
	rd_row_t rows [9] = '{
		'{16'h0010, 0, 0, 8'h00, 1, 16'hf708},
		'{16'h0011, 1, 0, 8'h00, 1, 16'h00f7},
		'{16'h0010, 1, 0, 8'h00, 1, 16'h0008},
		'{16'h3ffe, 0, 0, 8'h00, 1, 16'h00ff},
		'{16'h4000, 0, 0, 8'h00, 0, 16'h0000},
		'{16'h8004, 0, 1, 8'h01, 0, 16'h4002},
		'{16'h8005, 1, 1, 8'h01, 0, 16'h0040},
		'{16'h8004, 0, 0, 8'h01, 0, 16'h0000},
		'{16'h8004, 0, 1, 8'h7f, 0, 16'h0000}
	};
	mcu_address_space_decoder dut_u (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_pc_step(i_pc_step),
		.i_pc_back(i_pc_back),
		.i_pc_load(i_pc_load),
		.i_pc_target(i_pc_target),
		.i_table_read_op(i_table_read_op),
		.i_table_write_op(i_table_write_op),
		.i_table_page_select(i_table_page_select),
		.i_table_offset(i_table_offset),
		.i_rd_valid(i_rd_valid),
		.i_rd_byte_effective_address(i_rd_byte_effective_address),
		.i_rd_byte_op(i_rd_byte_op),
		.i_program_window_enable(i_program_window_enable),
		.i_visibility_page(i_visibility_page),
		.i_wr_valid(i_wr_valid),
		.i_wr_byte_effective_address(i_wr_byte_effective_address),
		.i_ram_rdata(i_ram_rdata),
		.i_prog_rdata(i_prog_rdata),
		.o_pc(o_pc),
		.o_prog_addr(o_prog_addr),
		.o_prog_en(o_prog_en),
		.o_prog_config(o_prog_config),
		.o_prog_region(o_prog_region),
		.o_ram_rd_addr(o_ram_rd_addr),
		.o_ram_rd_en(o_ram_rd_en),
		.o_ram_wr_addr(o_ram_wr_addr),
		.o_ram_wr_en(o_ram_wr_en),
		.o_rd_data(o_rd_data),
		.o_rd_data_valid(o_rd_data_valid));
	mem_partner mem_u (.i_ref_clk(i_ref_clk), .i_ram_rd_en(o_ram_rd_en),
		.i_ram_rd_addr(o_ram_rd_addr), .i_prog_en(o_prog_en), .i_prog_addr(o_prog_addr),
		.o_ram_rdata(i_ram_rdata), .o_prog_rdata(i_prog_rdata));
	initial
	begin
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic rd(input rd_row_t r);
		@(posedge i_ref_clk);
		i_rd_valid <= 1;
		i_rd_byte_effective_address <= r.addr;
		i_rd_byte_op <= r.bop;
		i_program_window_enable <= r.win;
		i_visibility_page <= r.page;
		@(posedge i_ref_clk);
		i_rd_valid <= 0;
		#1 check(o_ram_rd_en, r.ram_en);
		if (r.ram_en)
			check(o_ram_rd_addr, r.addr[14:1]);
		if (r.win && r.addr[15])
			check(o_prog_addr, {1'b0, r.page, r.addr[14:1], 1'b0});
		@(posedge i_ref_clk);
		#1 check(o_rd_data_valid, 1);
		check(o_rd_data, r.data);
	endtask : rd
	task automatic wr(input logic [15:0] addr, input logic en);
		@(posedge i_ref_clk);
		i_wr_valid <= 1;
		i_wr_byte_effective_address <= addr;
		i_rd_valid <= 1;
		i_rd_byte_effective_address <= 16'h0002;
		@(posedge i_ref_clk);
		{i_wr_valid, i_rd_valid} <= 2'b00;
		#1 check(o_ram_wr_en, en);
		check(o_ram_rd_en, 1);
		if (en)
			check(o_ram_wr_addr, addr[14:1]);
	endtask : wr
	task automatic tbl(input logic w, input logic [7:0] pg, input logic [15:0] off,
		input logic en, input logic [3:0] reg_exp);
		@(posedge i_ref_clk);
		{i_table_write_op, i_table_read_op} <= {w, ~w};
		i_table_page_select <= pg;
		i_table_offset <= off;
		@(posedge i_ref_clk);
		{i_table_write_op, i_table_read_op} <= 2'b00;
		#1 check(o_prog_addr, {pg, off[15:1], 1'b0});
		check(o_prog_config, pg[7]);
		check(o_prog_en, en);
		check(o_prog_region, reg_exp);
	endtask : tbl
	task automatic pc_op(input logic [2:0] lsb, input logic [22:0] tgt, input logic [22:0] exp);
		@(posedge i_ref_clk);
		{i_pc_load, i_pc_step, i_pc_back} <= lsb;
		i_pc_target <= tgt;
		@(posedge i_ref_clk);
		{i_pc_load, i_pc_step, i_pc_back} <= 3'b000;
		#1 check(o_pc, exp);
	endtask : pc_op
	initial
	begin
		repeat (2000) @(posedge i_ref_clk);
		miscompares++;
		print_verdict();
	end
	initial
	begin
		repeat (6) @(posedge i_ref_clk);
		check({o_pc, o_prog_region, o_rd_data_valid, o_ram_rd_en}, 0);
		i_rst_n <= 1;
		@(posedge i_ref_clk);
		#1 check(o_pc, RESET_JUMP_ADDR[22:0]);
		foreach (rows[k])
			rd(rows[k]);
		// Writes: RAM hit, above implemented RAM, window half
		wr(16'h0020, 1);
		wr(16'h4000, 0);
		wr(16'h8000, 0);
		tbl(0, 8'h00, 16'h0000, 1, REGION_RESET);
		tbl(0, 8'h00, 16'h0002, 1, REGION_RESET);
		tbl(0, 8'h00, 16'h0004, 1, REGION_IVT);
		tbl(1, 8'h00, 16'h01fe, 1, REGION_IVT);
		tbl(0, 8'h00, 16'h0200, 1, REGION_USER);
		tbl(0, 8'h7f, 16'hfffe, 0, REGION_USER);
		tbl(1, 8'h80, 16'h0010, 1, REGION_CONFIG);
		pc_op(3'b100, 23'h000101, 23'h000100);
		pc_op(3'b010, 23'h000000, 23'h000102);
		pc_op(3'b011, 23'h000000, 23'h000100);
		pc_op(3'b110, 23'h000200, 23'h000200);
		@(posedge i_ref_clk);
		i_rst_n <= 0;
		#1 check(o_pc, PC_RESET);
		@(posedge i_ref_clk);
		i_rst_n <= 1;
		pc_op(3'b010, 23'h000000, RESET_START_ADDR[22:0]);
		print_verdict();
	end
endmodule : mcu_address_space_decoder_test
